//--- include/dram_pin_map.svh
// offsets, field positions, codes and counts of the command pin decoder
`ifndef DRAM_PIN_MAP_SVH
`define DRAM_PIN_MAP_SVH

// ----------------------------------------------------------------
// command codes on {row, column, write} strobes
// ----------------------------------------------------------------
`define CMD_MODE_WRITE 3'h0
`define CMD_REFRESH 3'h1
`define CMD_PRECHARGE 3'h2
`define CMD_ACTIVATE 3'h3
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5

// ----------------------------------------------------------------
// mode register selection by bank_select
// ----------------------------------------------------------------
`define MR_ZERO_SEL 3'h0
`define MR_ONE_SEL 3'h1
`define MR_TWO_SEL 3'h2

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define MR0_BURST_LSB 0
`define MR0_BURST_OTF 2'h1
`define MR0_BURST_CHOP 2'h2
`define MR1_TSTROBE_BIT 11
`define MR1_RTT_B0 2
`define MR1_RTT_B1 6
`define MR1_RTT_B2 9
`define MR2_RTTWR_LSB 9
`define MR_RESET 15'h0000

// ----------------------------------------------------------------
// address fields and burst lengths
// ----------------------------------------------------------------
`define AUTO_CLOSE_BIT 10
`define BURST_HALVE_BIT 12
`define COL_WIDTH 10
`define BURST_FULL 4'h8
`define BURST_CHOPPED 4'h4
`define READ_BEATS_PER_EDGE 4'h2

`endif

//--- include/dram_pin_pkg.sv
// types shared by the command pin decoder
package dram_pin_pkg;

  typedef enum logic [3:0] {
    PWR_ON = 4'b0001,
    PWR_PD_PRE = 4'b0010,
    PWR_PD_ACT = 4'b0100,
    PWR_SREF = 4'b1000
  } power_state_e;

  typedef logic [14:0] addr_t;
  typedef logic [2:0] bank_t;

endpackage : dram_pin_pkg

//--- core/pin_sync.sv
// three-stage synchroniser with agreement filter and change pulse
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw pins
  input wire logic [W-1:0] pin,
  // filtered level and one-cycle change pulse
  output logic [W-1:0] lvl,
  output logic [W-1:0] chg
);

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // stage one feeds stage two only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // a new level counts only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
      end
    end
  endgenerate

  assign lvl = lvl_q;
  assign chg = lvl_q ^ lvl_d;

endmodule : pin_sync

//--- core/stream_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module stream_fifo #(
  parameter int W = 21,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  assign in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage is left unreset; the pointers alone define contents
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule : stream_fifo

//--- core/dram_command_pin_decode.sv
// command, address and control pin decoder of the memory device
//
// Overview of operation
// - capture inputs when true clock rises and complement clock falls
// - clock gate high keeps clocks, buffers, drivers on; low stops them
// - gate low: idle banks give precharge power-down or self-refresh
// - gate rise exits self-refresh without a link clock edge
// - power-down keeps clock, termination, gate; self-refresh only gate
// - commands are ignored while rank select is registered high
// - row, column, write strobes with rank select encode the command
// - termination on data, strobes, mask; strobe_n only with A11 set
// - termination input ignored when disabled or in self-refresh
// - a write beat sampled with the mask high is not stored
// - mode register one bit A11 picks mask or termination strobe
// - bank select names the bank, or the mode register to write
// - row from ADDRESS_BUS, column from A0-A9, opcode at mode write
// - auto close flag at read or write closes bank afterwards
// - precharge closes named bank, or all when flag is high
// - burst halve low at read or write chops that burst
// - low async clear resets the device at once
// - clearing the device destroys stored contents
// - bursts carry eight beats, or four when chopped
// - per-command chop works only when on-the-fly is enabled
`timescale 1ns/100ps
`include "dram_pin_map.svh"
module dram_command_pin_decode #(
  parameter int FIFO_DEPTH = 8
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link clock and control pins
  input wire logic clock_true,
  input wire logic clock_complement,
  input wire logic clk_gate_in,
  input wire logic rank_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire dram_pin_pkg::bank_t bank_select,
  input wire dram_pin_pkg::addr_t address_bus,
  input wire logic termination_enable,
  input wire logic async_clear_n,
  // data pins
  input wire logic [7:0] data_pins_in,
  output logic [7:0] data_pins_out,
  output logic data_pins_oe,
  input wire logic data_strobe,
  input wire logic data_strobe_n,
  input wire logic write_byte_mask,
  // termination state
  output logic term_data_on,
  output logic term_strobe_n_on,
  // write beat stream: {bank, column, data}
  output logic [20:0] beat_data,
  output logic beat_valid,
  input wire logic beat_ready,
  output logic beat_drop,
  // read data source
  input wire logic [7:0] read_beat,
  // status
  output dram_pin_pkg::power_state_e power_state,
  output logic [7:0] bank_open,
  output dram_pin_pkg::addr_t burst_row,
  output dram_pin_pkg::addr_t mode_reg_one,
  output dram_pin_pkg::addr_t mode_reg_two
);
  import dram_pin_pkg::*;

  // ----------------------------------------------------------------
  // reset and pin synchronisation
  // ----------------------------------------------------------------
  logic rst_n;
  // either reset clears everything, stored beats included
  assign rst_n = resetn & async_clear_n;

  localparam int SW = 37;
  logic [SW-1:0] raw, lvl, chg;
  assign raw = {clock_true, clock_complement, clk_gate_in, rank_select_n,
                row_strobe_n, column_strobe_n, write_strobe_n, bank_select,
                address_bus, termination_enable, data_strobe,
                data_strobe_n, write_byte_mask, data_pins_in};

  pin_sync #(.W(SW)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin(raw),
    .lvl(lvl),
    .chg(chg)
  );

  logic ck_l, ckn_l, gate_l, cs_n_l, odt_l, dqs_l, dqsn_l, dm_l;
  logic [2:0] cmd;
  bank_t ba;
  addr_t addr;
  logic [7:0] dq;
  assign ck_l = lvl[36];
  assign ckn_l = lvl[35];
  assign gate_l = lvl[34];
  assign cs_n_l = lvl[33];
  assign cmd = lvl[32:30];
  assign ba = lvl[29:27];
  assign addr = lvl[26:12];
  assign odt_l = lvl[11];
  assign dqs_l = lvl[10];
  assign dqsn_l = lvl[9];
  assign dm_l = lvl[8];
  assign dq = lvl[7:0];

  // ----------------------------------------------------------------
  // edges and command qualification
  // ----------------------------------------------------------------
  logic link_edge, strobe_edge, cmd_on, act_cmd;
  // the filtered levels still hold the old values while chg pulses
  assign link_edge = chg[36] & ~ck_l & ckn_l;
  // both strobe edges count, only with the pair in opposite states
  assign strobe_edge = chg[10] & (dqs_l ^ dqsn_l);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  power_state_e pwr_q, pwr_d;
  addr_t mr0_q, mr0_d, mr1_q, mr1_d, mr2_q, mr2_d;
  logic [7:0] open_q, open_d;
  addr_t row_q [8];
  addr_t row_d [8];
  logic [3:0] left_q, left_d;
  logic wr_q, wr_d, close_q, close_d, odt_q, odt_d, drop_q, drop_d;
  bank_t bk_q, bk_d;
  logic [`COL_WIDTH-1:0] col_q, col_d;
  addr_t brow_q, brow_d;
  logic [7:0] dout_q, dout_d;
  logic oe_q, oe_d;
  logic push, fifo_ready;

  // termination may act only when a mode register enables it
  function automatic logic term_allowed(input addr_t m1, input addr_t m2);
    term_allowed = m1[`MR1_RTT_B0] | m1[`MR1_RTT_B1] | m1[`MR1_RTT_B2] |
                   (|m2[`MR2_RTTWR_LSB +: 2]);
  endfunction : term_allowed

  // commands are taken only at a link edge, running, with gate high
  assign cmd_on = link_edge & (pwr_q == PWR_ON) & gate_l;
  assign act_cmd = cmd_on & ~cs_n_l;

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      PWR_ON: begin
        if (link_edge && !gate_l) begin
          if (|open_q) begin
            pwr_d = PWR_PD_ACT;
          end else if (!cs_n_l && cmd == `CMD_REFRESH) begin
            pwr_d = PWR_SREF;
          end else begin
            pwr_d = PWR_PD_PRE;
          end
        end
      end
      PWR_PD_PRE, PWR_PD_ACT: begin
        if (link_edge && gate_l) begin
          pwr_d = PWR_ON;
        end
      end
      PWR_SREF: begin
        // exit follows the gate alone; the link clock may be stopped
        if (gate_l) begin
          pwr_d = PWR_ON;
        end
      end
      default: pwr_d = PWR_ON;
    endcase
  end

  // ----------------------------------------------------------------
  // command decode, banks and bursts
  // ----------------------------------------------------------------
  always_comb begin
    mr0_d = mr0_q;
    mr1_d = mr1_q;
    mr2_d = mr2_q;
    open_d = open_q;
    row_d = row_q;
    left_d = left_q;
    wr_d = wr_q;
    close_d = close_q;
    bk_d = bk_q;
    col_d = col_q;
    brow_d = brow_q;
    odt_d = odt_q;
    drop_d = drop_q;
    push = 1'b0;
    // termination is sampled in power-down too, never in self-refresh
    if (link_edge && pwr_q != PWR_SREF) begin
      odt_d = odt_l;
    end
    if (act_cmd) begin
      unique case (cmd)
        `CMD_MODE_WRITE: begin
          if (ba == `MR_ZERO_SEL) mr0_d = addr;
          if (ba == `MR_ONE_SEL) mr1_d = addr;
          if (ba == `MR_TWO_SEL) mr2_d = addr;
        end
        `CMD_ACTIVATE: begin
          open_d[ba] = 1'b1;
          row_d[ba] = addr;
        end
        `CMD_PRECHARGE: begin
          if (addr[`AUTO_CLOSE_BIT]) begin
            open_d = '0;
          end else begin
            open_d[ba] = 1'b0;
          end
        end
        `CMD_WRITE, `CMD_READ: begin
          wr_d = cmd == `CMD_WRITE;
          bk_d = ba;
          col_d = addr[`COL_WIDTH-1:0];
          brow_d = row_q[ba];
          close_d = addr[`AUTO_CLOSE_BIT];
          left_d = `BURST_FULL;
          if (mr0_q[`MR0_BURST_LSB +: 2] == `MR0_BURST_CHOP) begin
            left_d = `BURST_CHOPPED;
          end else if (mr0_q[`MR0_BURST_LSB +: 2] == `MR0_BURST_OTF &&
                       !addr[`BURST_HALVE_BIT]) begin
            left_d = `BURST_CHOPPED;
          end
        end
        default: begin
        end
      endcase
    end else if (left_q != 4'h0) begin
      // write inputs are dead once the clock gate has stopped the device
      if (wr_q && strobe_edge && pwr_q == PWR_ON) begin
        left_d = left_q - 4'h1;
        col_d = col_q + 1'b1;
        // the mask pin means mask only while the strobe function is off
        push = !(dm_l && !mr1_q[`MR1_TSTROBE_BIT]);
      end else if (!wr_q && link_edge) begin
        left_d = left_q - `READ_BEATS_PER_EDGE;
      end
      if (left_d == 4'h0 && close_q) begin
        open_d[bk_q] = 1'b0;
      end
    end
    // the pins cannot be stalled, so a full fifo loses the beat
    if (push && !fifo_ready) begin
      drop_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read data drivers
  // ----------------------------------------------------------------
  always_comb begin
    oe_d = !wr_q && left_q != 4'h0 && pwr_q == PWR_ON && gate_l;
    dout_d = link_edge ? read_beat : dout_q;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= PWR_ON;
      mr0_q <= `MR_RESET;
      mr1_q <= `MR_RESET;
      mr2_q <= `MR_RESET;
      open_q <= '0;
      row_q <= '{default: '0};
      left_q <= '0;
      wr_q <= 1'b0;
      close_q <= 1'b0;
      bk_q <= '0;
      col_q <= '0;
      brow_q <= '0;
      odt_q <= 1'b0;
      drop_q <= 1'b0;
      oe_q <= 1'b0;
      dout_q <= '0;
    end else begin
      pwr_q <= pwr_d;
      mr0_q <= mr0_d;
      mr1_q <= mr1_d;
      mr2_q <= mr2_d;
      open_q <= open_d;
      row_q <= row_d;
      left_q <= left_d;
      wr_q <= wr_d;
      close_q <= close_d;
      bk_q <= bk_d;
      col_q <= col_d;
      brow_q <= brow_d;
      odt_q <= odt_d;
      drop_q <= drop_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
    end
  end

  // ----------------------------------------------------------------
  // beat buffer
  // ----------------------------------------------------------------
  stream_fifo #(.W(21), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_data({bk_q, col_q, dq}),
    .in_valid(push),
    .in_ready(fifo_ready),
    .out_data(beat_data),
    .out_valid(beat_valid),
    .out_ready(beat_ready)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    term_data_on = odt_q && pwr_q != PWR_SREF &&
                   term_allowed(mr1_q, mr2_q);
    term_strobe_n_on = term_data_on && mr1_q[`MR1_TSTROBE_BIT];
  end

  assign data_pins_out = dout_q;
  assign data_pins_oe = oe_q;
  assign beat_drop = drop_q;
  assign power_state = pwr_q;
  assign bank_open = open_q;
  assign burst_row = brow_q;
  assign mode_reg_one = mr1_q;
  assign mode_reg_two = mr2_q;

endmodule : dram_command_pin_decode

//--- testbench/dram_pin_checker.sv
// assertions on the command pin decoder ports
`timescale 1ns/100ps
module dram_pin_checker
  import dram_pin_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // observed pins
  input wire logic async_clear_n,
  input wire logic clk_gate_in,
  input wire logic data_pins_oe,
  input wire logic term_data_on,
  input wire logic term_strobe_n_on,
  input wire dram_pin_pkg::power_state_e power_state,
  input wire logic [7:0] bank_open,
  input wire dram_pin_pkg::addr_t mode_reg_one
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // ------
  // power gating, termination and clear
  // ------
  sequence gate_held_low;
    (!clk_gate_in)[*8] ##1 (!clk_gate_in)[*8];
  endsequence
  gate_stops_clock_a: assert property (gate_held_low |->
    power_state != PWR_ON) else $error("gate low but still on");
  drivers_need_on_a: assert property (data_pins_oe |->
    power_state == PWR_ON) else $error("driving while gated");
  sref_all_idle_a: assert property (power_state == PWR_SREF |->
    bank_open == 8'h00) else $error("self-refresh with open bank");
  pd_pre_idle_a: assert property (power_state == PWR_PD_PRE |->
    bank_open == 8'h00) else $error("precharge pd with open bank");
  pd_act_open_a: assert property ($rose(power_state == PWR_PD_ACT) |->
    bank_open != 8'h00) else $error("active pd with no open bank");
  sref_gate_exit_a: assert property (
    power_state == PWR_SREF && clk_gate_in |-> ##[1:8] power_state == PWR_ON)
    else $error("self-refresh exit late");
  sref_term_hold_a: assert property (
    power_state == PWR_SREF ##1 power_state == PWR_SREF |->
    $stable(term_data_on)) else $error("termination moved in self-refresh");
  strobe_n_mode_a: assert property (term_strobe_n_on |->
    mode_reg_one[11] && term_data_on) else $error("strobe_n term not enabled");
  clear_wipes_a: assert property ($rose(async_clear_n) |->
    bank_open == 8'h00 && mode_reg_one == 15'h0000)
    else $error("state kept over clear");
endmodule : dram_pin_checker

//--- testbench/mem_ctl_model.sv
// memory controller model driving link clock, command and write pins
`timescale 1ns/100ps
module mem_ctl_model (
  // link clock
  output logic clock_true,
  output logic clock_complement,
  // command group
  output logic clk_gate_in,
  output logic rank_select_n,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_strobe_n,
  output logic [2:0] bank_select,
  output logic [14:0] address_bus,
  // write data
  output logic [7:0] data_pins_in,
  output logic data_strobe,
  output logic data_strobe_n,
  output logic write_byte_mask
);
  assign clock_complement = ~clock_true;
  initial begin
    clock_true = 1'b0;
    clk_gate_in = 1'b1;
    rank_select_n = 1'b1;
    {row_strobe_n, column_strobe_n, write_strobe_n} = 3'h7;
    bank_select = 3'h0;
    address_bus = 15'h0000;
    data_pins_in = 8'h00;
    data_strobe = 1'b0;
    data_strobe_n = 1'b1;
    write_byte_mask = 1'b0;
  end
  always #200 clock_true = ~clock_true;
  // ------
  // transfers
  // ------
  // pins move mid-period so they sit still around the rising edge
  task automatic cmd(input logic cs_n, input logic [2:0] code,
    input logic [2:0] ba, input logic [14:0] a, input logic gate);
    @(negedge clock_true);
    #1;
    clk_gate_in = gate;
    rank_select_n = cs_n;
    {row_strobe_n, column_strobe_n, write_strobe_n} = code;
    bank_select = ba;
    address_bus = a;
    @(negedge clock_true);
    #1;
    rank_select_n = 1'b1;
    {row_strobe_n, column_strobe_n, write_strobe_n} = 3'h7;
    // released lines must not show a stale value
    bank_select = ~ba;
    address_bus = ~a;
    #300;
  endtask : cmd
  task automatic beats(input int n, input logic [7:0] base, input int skip);
    clk_gate_in = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clock_true);
      #1;
      data_pins_in = base + 8'(i);
      write_byte_mask = (i == skip);
      @(posedge clock_true);
      #1;
      data_strobe = ~data_strobe;
      data_strobe_n = ~data_strobe_n;
    end
    @(negedge clock_true);
    #1;
    data_pins_in = ~data_pins_in;
    write_byte_mask = 1'b0;
    #300;
  endtask : beats
endmodule : mem_ctl_model

//--- testbench/testbench.sv
// self-checking bench for the command pin decoder
`timescale 1ns/100ps
`include "dram_pin_map.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t %h %h", $time, (a), (b)); end end
module testbench;
  import dram_pin_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic async_clear_n = 1'b1;
  logic termination_enable = 1'b0;
  logic beat_ready = 1'b0;
  logic [7:0] read_beat = 8'h5A;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  wire clock_true, clock_complement, clk_gate_in, rank_select_n;
  wire row_strobe_n, column_strobe_n, write_strobe_n;
  wire [2:0] bank_select;
  wire [14:0] address_bus;
  wire [7:0] data_pins_in;
  wire data_strobe, data_strobe_n, write_byte_mask;
  logic [7:0] data_pins_out, bank_open;
  logic data_pins_oe, term_data_on, term_strobe_n_on, beat_valid, beat_drop;
  logic [20:0] beat_data;
  power_state_e power_state;
  addr_t burst_row, mode_reg_one, mode_reg_two;
  mem_ctl_model ctl (.*);
  dram_command_pin_decode #(.FIFO_DEPTH(8)) dut (.*);
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      end_sim();
    end
  end
  // ------
  // helpers
  // ------
  task automatic end_sim;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic op(input logic [2:0] c, input logic [2:0] b,
    input logic [14:0] a);
    ctl.cmd(1'b0, c, b, a, 1'b1);
  endtask : op
  task automatic drain(input int n, input int skip, input logic [9:0] col,
    input logic [7:0] base);
    int k;
    @(posedge sys_clk);
    #1;
    beat_ready = 1'b1;
    for (int i = 0; i < n; i++) begin
      if (i != skip) begin
        k = 0;
        @(negedge sys_clk);
        while (beat_valid !== 1'b1 && k < 50) begin
          @(negedge sys_clk);
          k++;
        end
        `CHK(beat_data, {3'h2, col + 10'(i), base + 8'(i)})
        @(posedge sys_clk);
      end
    end
    #1;
    beat_ready = 1'b0;
    @(negedge sys_clk);
    `CHK(beat_valid, 1'b0)
  endtask : drain
  // a chopped read stops driving within 14 cycles, a full one later
  task automatic read_len(input logic full);
    repeat (14) @(posedge sys_clk);
    #1;
    `CHK(data_pins_oe, full)
    repeat (26) @(posedge sys_clk);
    #1;
    `CHK(data_pins_oe, 1'b0)
  endtask : read_len
  // ------
  // scenarios
  // ------
  task automatic t_mode;
    op(`CMD_MODE_WRITE, `MR_ZERO_SEL, 15'h0001);
    op(`CMD_MODE_WRITE, `MR_ONE_SEL, 15'h0004);
    op(`CMD_MODE_WRITE, `MR_TWO_SEL, 15'h0600);
    `CHK(mode_reg_one, 15'h0004)
    `CHK(mode_reg_two, 15'h0600)
  endtask : t_mode
  task automatic t_access;
    op(`CMD_ACTIVATE, 3'h2, 15'h7ABC);
    ctl.cmd(1'b1, `CMD_ACTIVATE, 3'h6, 15'h0123, 1'b1);
    `CHK(bank_open, 8'h04)
    @(posedge sys_clk);
    #1;
    read_beat = 8'hA5;
    op(`CMD_READ, 3'h2, 15'h0008);
    `CHK(data_pins_oe, 1'b1)
    `CHK(data_pins_out, 8'hA5)
    `CHK(burst_row, 15'h7ABC)
    read_len(1'b0);
    op(`CMD_READ, 3'h2, 15'h1008);
    read_len(1'b1);
    // fixed length mode must ignore the halve bit
    op(`CMD_MODE_WRITE, `MR_ZERO_SEL, 15'h0000);
    op(`CMD_READ, 3'h2, 15'h0008);
    read_len(1'b1);
    op(`CMD_MODE_WRITE, `MR_ZERO_SEL, 15'h0001);
  endtask : t_access
  task automatic t_write;
    // chopped, masked second beat
    op(`CMD_WRITE, 3'h2, 15'h0010);
    ctl.beats(4, 8'h10, 1);
    drain(4, 1, 10'h010, 8'h10);
    `CHK(bank_open, 8'h04)
    // full burst with auto close fills the fifo, next burst overflows
    op(`CMD_WRITE, 3'h2, 15'h1420);
    ctl.beats(8, 8'h40, 99);
    `CHK(bank_open, 8'h00)
    `CHK(beat_drop, 1'b0)
    op(`CMD_ACTIVATE, 3'h2, 15'h0001);
    op(`CMD_WRITE, 3'h2, 15'h0030);
    ctl.beats(4, 8'h80, 99);
    `CHK(beat_drop, 1'b1)
    drain(8, 99, 10'h020, 8'h40);
  endtask : t_write
  task automatic t_close;
    op(`CMD_ACTIVATE, 3'h1, 15'h0000);
    op(`CMD_ACTIVATE, 3'h4, 15'h0000);
    op(`CMD_PRECHARGE, 3'h4, 15'h0000);
    `CHK(bank_open, 8'h06)
    op(`CMD_PRECHARGE, 3'h0, 15'h0400);
    `CHK(bank_open, 8'h00)
  endtask : t_close
  task automatic t_power;
    op(`CMD_ACTIVATE, 3'h1, 15'h0000);
    ctl.cmd(1'b0, `CMD_ACTIVATE, 3'h5, 15'h0000, 1'b0);
    `CHK(power_state, PWR_PD_ACT)
    `CHK(bank_open, 8'h02)
    ctl.cmd(1'b1, 3'h7, 3'h0, 15'h0000, 1'b1);
    `CHK(power_state, PWR_ON)
    op(`CMD_PRECHARGE, 3'h0, 15'h0400);
    ctl.cmd(1'b1, 3'h7, 3'h0, 15'h0000, 1'b0);
    `CHK(power_state, PWR_PD_PRE)
    ctl.cmd(1'b1, 3'h7, 3'h0, 15'h0000, 1'b1);
    ctl.cmd(1'b0, `CMD_REFRESH, 3'h0, 15'h0000, 1'b0);
    `CHK(power_state, PWR_SREF)
    @(posedge sys_clk);
    #1;
    termination_enable = 1'b1;
    repeat (20) @(posedge sys_clk);
    #1;
    `CHK(term_data_on, 1'b0)
    ctl.clk_gate_in = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK(power_state, PWR_ON)
    repeat (20) @(posedge sys_clk);
    #1;
    `CHK(term_data_on, 1'b1)
    `CHK(term_strobe_n_on, 1'b0)
    op(`CMD_MODE_WRITE, `MR_ONE_SEL, 15'h0804);
    `CHK(term_strobe_n_on, 1'b1)
    // no termination value left in either mode register
    op(`CMD_MODE_WRITE, `MR_TWO_SEL, 15'h0000);
    op(`CMD_MODE_WRITE, `MR_ONE_SEL, 15'h0800);
    `CHK(term_data_on, 1'b0)
  endtask : t_power
  task automatic t_clear;
    op(`CMD_ACTIVATE, 3'h3, 15'h0000);
    @(posedge sys_clk);
    #1;
    async_clear_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(mode_reg_one, 15'h0000)
    `CHK(bank_open, 8'h00)
    `CHK(power_state, PWR_ON)
    async_clear_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    // the device must take commands again after the clear
    op(`CMD_ACTIVATE, 3'h7, 15'h0000);
    `CHK(bank_open, 8'h80)
  endtask : t_clear
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (6) @(posedge sys_clk);
    t_mode();
    t_access();
    t_write();
    t_close();
    t_power();
    t_clear();
    end_sim();
  end
endmodule : testbench
bind dram_command_pin_decode dram_pin_checker chk (.sys_clk(sys_clk),
  .resetn(resetn), .async_clear_n(async_clear_n),
  .clk_gate_in(clk_gate_in), .data_pins_oe(data_pins_oe),
  .term_data_on(term_data_on), .term_strobe_n_on(term_strobe_n_on),
  .power_state(power_state), .bank_open(bank_open),
  .mode_reg_one(mode_reg_one));
